//--- rtl/input_cell_group.sv
// Four input cells that share one latch gate or register clock.
`timescale 1ns/1ps
module input_cell_group #(
    parameter int         WIDTH = 4,
    parameter logic [7:0] MODES = 8'h00
) (
    input  wire logic             core_clk_i,
    input  wire logic             rst_n_i,
    input  wire logic             gate_i,
    input  wire logic [WIDTH-1:0] pins_i,
    output logic      [WIDTH-1:0] cells_o
);
    import macrocell_pkg::*;

    logic             gate_prev_ff;
    logic [WIDTH-1:0] cells_ff;
    logic [WIDTH-1:0] nxt_cells;
    logic             gate_rise;

    // Each cell latches, registers or passes its pin, by its own mode.
    always_comb begin
        gate_rise = gate_i && !gate_prev_ff;
        nxt_cells = cells_ff;
        for (int i = 0; i < WIDTH; i++) begin
            unique case (MODES[2*i +: 2])
                MODE_LATCH:    if (gate_i) nxt_cells[i] = pins_i[i];
                MODE_REGISTER: if (gate_rise) nxt_cells[i] = pins_i[i];
                default:       nxt_cells[i] = pins_i[i];
            endcase
        end
    end

    // Holds the cell state and the gate history for edge detection.
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cells_ff     <= '0;
            gate_prev_ff <= 1'b0;
        end else begin
            cells_ff     <= nxt_cells;
            gate_prev_ff <= gate_i;
        end
    end

    assign cells_o = cells_ff;

endmodule : input_cell_group

//--- rtl/macrocell_pkg.sv
// Shared constants and types for the programmable-logic macrocell access block.
package macrocell_pkg;

    // -------------------------------------------------------------------
    // Widths.
    // -------------------------------------------------------------------
    localparam int GROUP_WIDTH  = 8;
    localparam int OUT_CELLS    = 16;
    localparam int IN_CELLS     = 24;
    localparam int GATE_SHARE   = 4;
    localparam int GATE_TERMS   = IN_CELLS / GATE_SHARE;
    localparam int SELECT_OUTS  = 8;
    localparam int REG_SEL_W    = 3;

    // -------------------------------------------------------------------
    // Register select codes seen on the MCU location select lines.
    // -------------------------------------------------------------------
    localparam logic [REG_SEL_W-1:0] SEL_CELLS_A = 3'h0;
    localparam logic [REG_SEL_W-1:0] SEL_CELLS_B = 3'h1;
    localparam logic [REG_SEL_W-1:0] SEL_BLOCK_A = 3'h2;
    localparam logic [REG_SEL_W-1:0] SEL_BLOCK_B = 3'h3;
    localparam logic [REG_SEL_W-1:0] SEL_INPUT_A = 3'h4;
    localparam logic [REG_SEL_W-1:0] SEL_INPUT_B = 3'h5;
    localparam logic [REG_SEL_W-1:0] SEL_INPUT_C = 3'h6;

    // -------------------------------------------------------------------
    // Reset values.
    // -------------------------------------------------------------------
    localparam logic [GROUP_WIDTH-1:0] BLOCK_RESET = 8'h00;
    localparam logic [GROUP_WIDTH-1:0] BYTE_ZERO   = 8'h00;

    // -------------------------------------------------------------------
    // Input cell operating modes, two bits per cell in the mode vector.
    // -------------------------------------------------------------------
    localparam logic [1:0] MODE_PASS     = 2'h0;
    localparam logic [1:0] MODE_LATCH    = 2'h1;
    localparam logic [1:0] MODE_REGISTER = 2'h2;

endpackage : macrocell_pkg

//--- rtl/pld_macrocell_io_access.sv
// Macrocell load, mask, pin enable, input cell and external select logic.
`timescale 1ns/1ps
// Overview of operation
// - Two write-block registers, one per group of eight, both reset to zero.
// - A set block bit stops MCU writes changing that output cell.
// - Block bit n guards cell n of its group.
// - Pin driver enable is the enable product term OR the direction bit.
// - Output pins with no enable equation drive from reset onward.
// - Cells used as internal nodes never drive their pin but still feed back.
// - Twenty-four input cells, one per pin of ports A, B and C.
// - Each input cell is a latch, a register or a pass-through.
// - MCU reads input cell outputs over the internal data bus.
// - Input gate comes from a product term or the address strobe.
// - One gate term serves bits 3-0, another bits 7-4, of each port.
// - Address-strobe clocked cells capture high address bits for the logic.
// - Mailbox: master writes port A data, slave writes port A input cells.
// - Slave read and write terms come from slave strobes and slave select.
// - Eight external selects, one product term each, selectable polarity.
// - External select driver enabled by its enable term or direction bit.
// - An MCU load overrides preset, clear and clock of the cell.
// - MCU loads act on the trailing edge of the write strobe.
// - Cells clocked by the dedicated clock pin update on its rising edge.
module pld_macrocell_io_access #(
    parameter logic [15:0] CLOCK_FROM_PIN = 16'h0000,
    parameter logic [15:0] INTERNAL_NODE  = 16'h0000,
    parameter logic [15:0] NO_OE_EQUATION = 16'h0000,
    parameter logic [47:0] INPUT_MODES    = 48'h0,
    parameter logic [5:0]  GATE_FROM_AS   = 6'h00,
    parameter logic [7:0]  SELECT_ACT_LOW = 8'h00
) (
    input  wire logic                                   core_clk_i,
    input  wire logic                                   rst_n_i,
    input  wire logic                                   mcu_select_i,
    input  wire logic [macrocell_pkg::REG_SEL_W-1:0]    reg_sel_i,
    input  wire logic                                   write_strobe_pin_n_i,
    input  wire logic                                   read_strobe_pin_n_i,
    input  wire logic                                   address_latch_strobe_i,
    input  wire logic [macrocell_pkg::GROUP_WIDTH-1:0]  address_data_port_i,
    output logic      [macrocell_pkg::GROUP_WIDTH-1:0]  address_data_port_o,
    output logic                                        address_data_port_oe_o,
    input  wire logic                                   dedicated_logic_clock_pin_i,
    input  wire logic [macrocell_pkg::OUT_CELLS-1:0]    pt_data_i,
    input  wire logic [macrocell_pkg::OUT_CELLS-1:0]    pt_clock_i,
    input  wire logic [macrocell_pkg::OUT_CELLS-1:0]    pt_preset_i,
    input  wire logic [macrocell_pkg::OUT_CELLS-1:0]    pt_clear_i,
    input  wire logic [macrocell_pkg::OUT_CELLS-1:0]    pt_out_enable_i,
    input  wire logic [macrocell_pkg::OUT_CELLS-1:0]    direction_i,
    output logic      [macrocell_pkg::OUT_CELLS-1:0]    output_cell_pin_o,
    output logic      [macrocell_pkg::OUT_CELLS-1:0]    output_cell_pin_oe_o,
    output logic      [macrocell_pkg::OUT_CELLS-1:0]    output_cell_feedback_o,
    input  wire logic [macrocell_pkg::IN_CELLS-1:0]     port_abc_pins_i,
    input  wire logic [macrocell_pkg::GATE_TERMS-1:0]   pt_input_gate_i,
    output logic      [macrocell_pkg::IN_CELLS-1:0]     input_cell_o,
    input  wire logic                                   slave_read_n_i,
    input  wire logic                                   slave_write_n_i,
    input  wire logic                                   slave_select_n_i,
    output logic                                        slave_read_term_o,
    output logic                                        slave_write_term_o,
    input  wire logic [macrocell_pkg::SELECT_OUTS-1:0]  pt_select_i,
    input  wire logic [macrocell_pkg::SELECT_OUTS-1:0]  pt_select_oe_i,
    input  wire logic [macrocell_pkg::SELECT_OUTS-1:0]  select_direction_i,
    output logic      [macrocell_pkg::SELECT_OUTS-1:0]  external_select_outputs_o,
    output logic      [macrocell_pkg::SELECT_OUTS-1:0]  external_select_oe_o
);
    import macrocell_pkg::*;

    // -------------------------------------------------------------------
    // State.
    // -------------------------------------------------------------------
    logic [GROUP_WIDTH-1:0] block_a_ff;
    logic [GROUP_WIDTH-1:0] block_b_ff;
    logic [GROUP_WIDTH-1:0] nxt_block_a;
    logic [GROUP_WIDTH-1:0] nxt_block_b;
    logic [OUT_CELLS-1:0]   cells_ff;
    logic [OUT_CELLS-1:0]   nxt_cells;
    logic [OUT_CELLS-1:0]   pin_oe_ff;
    logic [OUT_CELLS-1:0]   nxt_pin_oe;
    logic [OUT_CELLS-1:0]   pt_clock_prev_ff;
    logic                   wr_prev_ff;
    logic                   clk_pin_prev_ff;
    logic [GROUP_WIDTH-1:0] rd_data_ff;
    logic [GROUP_WIDTH-1:0] nxt_rd_data;
    logic                   rd_oe_ff;
    logic                   nxt_rd_oe;
    logic                   slave_rd_ff;
    logic                   slave_wr_ff;
    logic                   nxt_slave_rd;
    logic                   nxt_slave_wr;
    logic [SELECT_OUTS-1:0] sel_out_ff;
    logic [SELECT_OUTS-1:0] sel_oe_ff;
    logic [SELECT_OUTS-1:0] nxt_sel_out;
    logic [SELECT_OUTS-1:0] nxt_sel_oe;
    logic [IN_CELLS-1:0]    in_cells;
    logic [GATE_TERMS-1:0]  gate_sel;
    logic                   wr_trail;
    logic                   clk_pin_rise;
    logic                   load_a;
    logic                   load_b;
    logic [OUT_CELLS-1:0]   load_mask;

    localparam logic [OUT_CELLS-1:0] PIN_OE_RESET = NO_OE_EQUATION & ~INTERNAL_NODE;

    // -------------------------------------------------------------------
    // Write strobe and clock pin edges.
    // -------------------------------------------------------------------

    // A load happens when the active-low write strobe returns high.
    assign wr_trail     = write_strobe_pin_n_i && !wr_prev_ff && mcu_select_i;
    assign clk_pin_rise = dedicated_logic_clock_pin_i && !clk_pin_prev_ff;
    assign load_a       = wr_trail && (reg_sel_i == SEL_CELLS_A);
    assign load_b       = wr_trail && (reg_sel_i == SEL_CELLS_B);

    // Block bit n gates the load of cell n in its own group only.
    assign load_mask = {{GROUP_WIDTH{load_b}} & ~block_b_ff,
                        {GROUP_WIDTH{load_a}} & ~block_a_ff};

    // -------------------------------------------------------------------
    // Block registers and output cells.
    // -------------------------------------------------------------------

    // Next state of the block registers, the cells and the pin enables.
    always_comb begin
        nxt_block_a = block_a_ff;
        nxt_block_b = block_b_ff;
        if (wr_trail && (reg_sel_i == SEL_BLOCK_A)) begin
            nxt_block_a = address_data_port_i;
        end
        if (wr_trail && (reg_sel_i == SEL_BLOCK_B)) begin
            nxt_block_b = address_data_port_i;
        end
        nxt_cells  = cells_ff;
        nxt_pin_oe = '0;
        for (int i = 0; i < OUT_CELLS; i++) begin
            // MCU load wins over preset, clear and clock.
            if (load_mask[i]) begin
                nxt_cells[i] = address_data_port_i[i % GROUP_WIDTH];
            end else if (pt_preset_i[i]) begin
                nxt_cells[i] = 1'b1;
            end else if (pt_clear_i[i]) begin
                nxt_cells[i] = 1'b0;
            end else if (CLOCK_FROM_PIN[i] ? clk_pin_rise
                         : (pt_clock_i[i] && !pt_clock_prev_ff[i])) begin
                nxt_cells[i] = pt_data_i[i];
            end
            // Internal nodes release the pin; pins with no enable equation drive; others follow term OR direction.
            if (INTERNAL_NODE[i]) begin
                nxt_pin_oe[i] = 1'b0;
            end else if (NO_OE_EQUATION[i]) begin
                nxt_pin_oe[i] = 1'b1;
            end else begin
                nxt_pin_oe[i] = pt_out_enable_i[i] | direction_i[i];
            end
        end
        // The slave read term also drives the port A mailbox pins.
        for (int i = 0; i < GROUP_WIDTH; i++) begin
            if (!INTERNAL_NODE[i] && !slave_read_n_i && !slave_select_n_i) begin
                nxt_pin_oe[i] = 1'b1;
            end
        end
    end

    // Registers the block, cell and pin enable state.
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            block_a_ff       <= BLOCK_RESET;
            block_b_ff       <= BLOCK_RESET;
            cells_ff         <= '0;
            pin_oe_ff        <= PIN_OE_RESET;
            pt_clock_prev_ff <= '0;
            wr_prev_ff       <= 1'b1;
            clk_pin_prev_ff  <= 1'b0;
        end else begin
            block_a_ff       <= nxt_block_a;
            block_b_ff       <= nxt_block_b;
            cells_ff         <= nxt_cells;
            pin_oe_ff        <= nxt_pin_oe;
            pt_clock_prev_ff <= pt_clock_i;
            wr_prev_ff       <= write_strobe_pin_n_i;
            clk_pin_prev_ff  <= dedicated_logic_clock_pin_i;
        end
    end

    assign output_cell_pin_o      = cells_ff;
    assign output_cell_feedback_o = cells_ff;
    assign output_cell_pin_oe_o   = pin_oe_ff;

    // -------------------------------------------------------------------
    // Input cells.
    // -------------------------------------------------------------------

    // Six shared gates, each chosen from its term or the address strobe.
    genvar g;
    generate
        for (g = 0; g < GATE_TERMS; g++) begin : gen_in_group
            assign gate_sel[g] = GATE_FROM_AS[g] ? address_latch_strobe_i
                                                 : pt_input_gate_i[g];
            input_cell_group #(
                .WIDTH (GATE_SHARE),
                .MODES (INPUT_MODES[2*GATE_SHARE*g +: 2*GATE_SHARE])
            ) u_group (
                .core_clk_i (core_clk_i),
                .rst_n_i    (rst_n_i),
                .gate_i     (gate_sel[g]),
                .pins_i     (port_abc_pins_i[GATE_SHARE*g +: GATE_SHARE]),
                .cells_o    (in_cells[GATE_SHARE*g +: GATE_SHARE])
            );
        end
    endgenerate

    assign input_cell_o = in_cells;

    // -------------------------------------------------------------------
    // MCU read-back, slave terms and external selects.
    // -------------------------------------------------------------------

    // Read mux onto the internal data bus while the read strobe is low.
    always_comb begin
        nxt_rd_oe   = mcu_select_i && !read_strobe_pin_n_i;
        nxt_rd_data = BYTE_ZERO;
        unique case (reg_sel_i)
            SEL_CELLS_A: nxt_rd_data = cells_ff[GROUP_WIDTH-1:0];
            SEL_CELLS_B: nxt_rd_data = cells_ff[OUT_CELLS-1:GROUP_WIDTH];
            SEL_BLOCK_A: nxt_rd_data = block_a_ff;
            SEL_BLOCK_B: nxt_rd_data = block_b_ff;
            SEL_INPUT_A: nxt_rd_data = in_cells[7:0];
            SEL_INPUT_B: nxt_rd_data = in_cells[15:8];
            SEL_INPUT_C: nxt_rd_data = in_cells[23:16];
            default:     nxt_rd_data = BYTE_ZERO;
        endcase
        nxt_sel_out = pt_select_i ^ SELECT_ACT_LOW;
        nxt_sel_oe  = pt_select_oe_i | select_direction_i;
        nxt_slave_rd = !slave_read_n_i && !slave_select_n_i;
        nxt_slave_wr = !slave_write_n_i && !slave_select_n_i;
    end

    // Registers the read bus, slave terms and select outputs.
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rd_data_ff  <= BYTE_ZERO;
            rd_oe_ff    <= 1'b0;
            slave_rd_ff <= 1'b0;
            slave_wr_ff <= 1'b0;
            sel_out_ff  <= SELECT_ACT_LOW;
            sel_oe_ff   <= '0;
        end else begin
            rd_data_ff  <= nxt_rd_data;
            rd_oe_ff    <= nxt_rd_oe;
            slave_rd_ff <= nxt_slave_rd;
            slave_wr_ff <= nxt_slave_wr;
            sel_out_ff  <= nxt_sel_out;
            sel_oe_ff   <= nxt_sel_oe;
        end
    end

    assign address_data_port_o       = rd_data_ff;
    assign address_data_port_oe_o    = rd_oe_ff;
    assign slave_read_term_o         = slave_rd_ff;
    assign slave_write_term_o        = slave_wr_ff;
    assign external_select_outputs_o = sel_out_ff;
    assign external_select_oe_o      = sel_oe_ff;

    // -------------------------------------------------------------------
    // Checks.
    // -------------------------------------------------------------------
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);

    chk_blocked_hold: assert property (
        load_a && block_a_ff[0] && !pt_preset_i[0] && !pt_clear_i[0]
        && !pt_clock_i[0] && !dedicated_logic_clock_pin_i
        |=> cells_ff[0] == $past(cells_ff[0]))
        else $error("Blocked cell changed on an MCU write.");

    chk_unblocked_load: assert property (
        $rose(write_strobe_pin_n_i) && mcu_select_i && (reg_sel_i == SEL_CELLS_B)
        && !block_b_ff[3] |=> cells_ff[11] == $past(address_data_port_i[3]))
        else $error("Unblocked cell failed to load.");

    chk_load_priority: assert property (
        load_a && !block_a_ff[1] && (pt_preset_i[1] || pt_clear_i[1])
        |=> cells_ff[1] == $past(address_data_port_i[1]))
        else $error("Preset or clear beat an MCU load.");

    chk_no_early_load: assert property (
        !write_strobe_pin_n_i && !pt_preset_i[2] && !pt_clear_i[2] && !pt_clock_i[2]
        && !dedicated_logic_clock_pin_i |=> $stable(cells_ff[2]))
        else $error("Cell loaded while the write strobe was still low.");

    chk_pin_enable: assert property (
        (pt_out_enable_i[12] || direction_i[12]) && !INTERNAL_NODE[12]
        |=> output_cell_pin_oe_o[12])
        else $error("Pin driver not enabled by term or direction.");

    chk_internal_node: assert property (
        ((output_cell_pin_oe_o & INTERNAL_NODE) == '0))
        else $error("Internal node drives its pin.");

    chk_select_polarity: assert property (
        ##1 external_select_outputs_o == ($past(pt_select_i) ^ SELECT_ACT_LOW))
        else $error("External select polarity wrong.");

    chk_select_enable: assert property (
        (pt_select_oe_i[5] || select_direction_i[5]) |=> external_select_oe_o[5])
        else $error("External select driver not enabled.");

    chk_select_release: assert property (
        !pt_select_oe_i[5] && !select_direction_i[5] |=> !external_select_oe_o[5])
        else $error("External select driver enabled with no term or direction.");

    chk_read_back: assert property (
        mcu_select_i && !read_strobe_pin_n_i && (reg_sel_i == SEL_INPUT_C)
        |=> address_data_port_oe_o && address_data_port_o == $past(in_cells[23:16]))
        else $error("Input cell read-back wrong.");

    chk_slave_terms: assert property (
        !slave_write_n_i && !slave_select_n_i |=> slave_write_term_o ##1 1'b1)
        else $error("Slave write term not formed.");

endmodule : pld_macrocell_io_access

//--- test/mcu_model.sv
// Bus master model of the MCU that loads and reads the macrocell locations.
`timescale 1ns/1ps
module mcu_model (
    input  wire logic                                core_clk_i,
    output logic                                     mcu_select_o,
    output logic [macrocell_pkg::REG_SEL_W-1:0]      reg_sel_o,
    output logic                                     write_strobe_n_o,
    output logic                                     read_strobe_n_o,
    output logic [macrocell_pkg::GROUP_WIDTH-1:0]    data_o
);
    import macrocell_pkg::*;

    // Idle bus: strobes high, no location selected.
    initial begin
        mcu_select_o     = 1'b0;
        reg_sel_o        = 3'h7;
        write_strobe_n_o = 1'b1;
        read_strobe_n_o  = 1'b1;
        data_o           = 8'h00;
    end

    // Load cycle: strobe low for a cycle, then high; the load lands on the rising strobe.
    task automatic write_reg(input logic [REG_SEL_W-1:0] sel, input logic [7:0] data);
        @(posedge core_clk_i);
        mcu_select_o     <= 1'b1;
        reg_sel_o        <= sel;
        data_o           <= data;
        write_strobe_n_o <= 1'b0;
        @(posedge core_clk_i);
        write_strobe_n_o <= 1'b1;
        @(posedge core_clk_i);
        mcu_select_o     <= 1'b0;
        data_o           <= ~data; // Released bus no longer shows the old byte.
    endtask : write_reg

    // Read cycle: strobe low for exactly one sampling edge.
    task automatic read_reg(input logic [REG_SEL_W-1:0] sel);
        @(posedge core_clk_i);
        mcu_select_o    <= 1'b1;
        reg_sel_o       <= sel;
        read_strobe_n_o <= 1'b0;
        @(posedge core_clk_i);
        mcu_select_o    <= 1'b0;
        read_strobe_n_o <= 1'b1;
    endtask : read_reg
endmodule : mcu_model

//--- test/test_pld_macrocell_io_access.sv
// Self-checking testbench for the macrocell access block.
`timescale 1ns/1ps
module test_pld_macrocell_io_access;
    import macrocell_pkg::*;
    localparam logic [15:0] INT_NODE = 16'h8000;
    localparam logic [15:0] NO_OE    = 16'h0001;
    localparam logic [7:0]  ACT_LOW  = 8'h0f;

    logic clk = 1'b0, rst_n = 1'b0, als = 1'b0, srd_n = 1'b1, swr_n = 1'b1, ssel_n = 1'b1;
    logic [15:0] zero16 = 16'h0000, pt_oe = 16'h0000, dir = 16'h0000;
    logic [23:0] pins = 24'h000000;
    logic [15:0] pre = 16'h0000;
    logic        clk_pin = 1'b0;
    logic [5:0]  gate = 6'h00;
    logic [7:0]  pt_sel = 8'h00, pt_sel_oe = 8'h00, sel_dir = 8'h00, v, r, rdata;
    logic [15:0] pin, pin_oe, fb;
    logic [23:0] icell;
    logic [7:0]  sel_out, sel_oe;
    logic        sel, wr_n, rd_n, rd_oe, srd_t, swr_t;
    logic [2:0]  rsel;
    logic [7:0]  wdata;
    logic [7:0]  expq[$];
    integer      seed = 32'h8c3a, n_errors = 0, total_checks = 0, i;

    always #20 clk = ~clk;

    mcu_model mcu (.core_clk_i(clk), .mcu_select_o(sel), .reg_sel_o(rsel),
        .write_strobe_n_o(wr_n), .read_strobe_n_o(rd_n), .data_o(wdata));

    pld_macrocell_io_access #(.CLOCK_FROM_PIN(16'h0040), .INTERNAL_NODE(INT_NODE),
        .NO_OE_EQUATION(NO_OE), .INPUT_MODES(48'haaaa_5555_0000), .GATE_FROM_AS(6'h30),
        .SELECT_ACT_LOW(ACT_LOW)) DUT (
        .core_clk_i(clk), .rst_n_i(rst_n), .mcu_select_i(sel), .reg_sel_i(rsel),
        .write_strobe_pin_n_i(wr_n), .read_strobe_pin_n_i(rd_n), .address_latch_strobe_i(als),
        .address_data_port_i(wdata), .address_data_port_o(rdata), .address_data_port_oe_o(rd_oe),
        .dedicated_logic_clock_pin_i(clk_pin), .pt_data_i(zero16), .pt_clock_i(zero16),
        .pt_preset_i(pre), .pt_clear_i(zero16), .pt_out_enable_i(pt_oe), .direction_i(dir),
        .output_cell_pin_o(pin), .output_cell_pin_oe_o(pin_oe), .output_cell_feedback_o(fb),
        .port_abc_pins_i(pins), .pt_input_gate_i(gate), .input_cell_o(icell),
        .slave_read_n_i(srd_n), .slave_write_n_i(swr_n), .slave_select_n_i(ssel_n),
        .slave_read_term_o(srd_t), .slave_write_term_o(swr_t), .pt_select_i(pt_sel),
        .pt_select_oe_i(pt_sel_oe), .select_direction_i(sel_dir),
        .external_select_outputs_o(sel_out), .external_select_oe_o(sel_oe));

    // Compares one observed value with its expectation and counts both outcomes.
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        total_checks = total_checks + 1;
        if (seen !== exp) begin
            n_errors = n_errors + 1;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Prints the counts and the verdict, then ends the run.
    task automatic report_and_stop;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : report_and_stop

    // Lets a registered copy of the inputs reach the outputs.
    task automatic settle;
        repeat (3) @(posedge clk);
        #1;
    endtask : settle

    // Issues a read and notes the byte that must come back.
    task automatic rd(input logic [2:0] code, input logic [7:0] exp);
        expq.push_back(exp);
        mcu.read_reg(code);
        for (i = 0; i < 20 && expq.size() != 0; i++) @(posedge clk);
        if (expq.size() != 0) begin
            check(24'h1, 24'h0); // A read answer never came.
            report_and_stop();
        end
    endtask : rd

    // Takes the oldest noted byte whenever the read data drive is enabled.
    always @(posedge clk) begin
        if (rd_oe === 1'b1) begin
            if (expq.size() == 0) check(24'h1, 24'h0); // An answer that nobody asked for.
            else check(rdata, expq.pop_front());
        end
    end

    // Main sequence.
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        settle();
        check(pin_oe, NO_OE & ~INT_NODE);
        rd(SEL_BLOCK_A, 8'h00);
        rd(SEL_BLOCK_B, 8'h00);
        rd(3'h7, 8'h00);
        mcu.write_reg(SEL_CELLS_A, 8'ha5);
        settle();
        check(pin[7:0], 8'ha5);
        mcu.write_reg(SEL_BLOCK_A, 8'h0f);
        rd(SEL_BLOCK_A, 8'h0f);
        mcu.write_reg(SEL_CELLS_A, 8'h5a);
        rd(SEL_CELLS_A, 8'h55);
        for (int k = 0; k < 4; k++) begin
            v = $random(seed);
            mcu.write_reg(SEL_CELLS_B, v);
            settle();
            check(pin[15:8], v);
            check({fb[15], pin_oe[15]}, {v[7], 1'b0});
        end
        mcu.write_reg(SEL_BLOCK_B, 8'hff);
        mcu.write_reg(SEL_CELLS_B, ~v);
        rd(SEL_CELLS_B, v);
        for (int k = 0; k < 4; k++) begin
            @(posedge clk);
            pt_oe     <= $random(seed);
            dir       <= $random(seed);
            pt_sel    <= $random(seed);
            pt_sel_oe <= $random(seed);
            sel_dir   <= $random(seed);
            settle();
            check(pin_oe, (pt_oe | dir | NO_OE) & ~INT_NODE);
            check(sel_out, pt_sel ^ ACT_LOW);
            check(sel_oe, pt_sel_oe | sel_dir);
        end
        @(posedge clk);
        pt_oe  <= 16'h0000;
        dir    <= 16'h0000;
        srd_n  <= 1'b0;
        ssel_n <= 1'b0;
        settle();
        check({srd_t, swr_t, pin_oe[7:0]}, {2'b10, 8'hff});
        @(posedge clk);
        srd_n <= 1'b1;
        swr_n <= 1'b0;
        settle();
        check({srd_t, swr_t}, 2'b01);
        r = $random(seed);
        @(posedge clk);
        swr_n     <= 1'b1;
        pins[7:0] <= r;
        gate      <= 6'h0c;
        pins[15:8] <= ~r;
        settle();
        rd(SEL_INPUT_A, r);
        gate <= 6'h00;
        settle();
        @(posedge clk);
        pins[15:8] <= r;
        settle();
        rd(SEL_INPUT_B, ~r);
        gate <= 6'h04;
        settle();
        rd(SEL_INPUT_B, {~r[7:4], r[3:0]});
        gate        <= 6'h00;
        pins[23:16] <= r;
        settle();
        @(posedge clk);
        als <= 1'b1;
        settle();
        @(posedge clk);
        als         <= 1'b0;
        pins[23:16] <= ~r;
        settle();
        rd(SEL_INPUT_C, r);
        // A rise on the logic clock pin loads cell 6 from its data term, which is low.
        clk_pin <= 1'b1;
        settle();
        check(icell, {r, ~r[7:4], r[3:0], r});
        check(pin[7:0], 8'h15);
        // Preset held on cells 0 and 1 loses to the MCU load, then sets them again.
        mcu.write_reg(SEL_BLOCK_A, 8'h00);
        pre <= 16'h0003;
        mcu.write_reg(SEL_CELLS_A, 8'h80);
        #1;
        check(pin[7:0], 8'h80);
        settle();
        check(pin[7:0], 8'h83);
        report_and_stop();
    end
endmodule : test_pld_macrocell_io_access
